// *** design/sfi_pkg.sv ***
/*
  Shared constants and types for the serial flash command front end:
  command codes, status word layout, phase lengths, pin indices, states.
  Assumes the importing modules run on one system clock with an active-low reset.
*/
package sfi_pkg;
  // command codes
  localparam logic [7:0] CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
  localparam logic [7:0] CMD_STAT_LO = 8'h05;
  localparam logic [7:0] CMD_STAT_HI = 8'h35;
  localparam logic [7:0] CMD_STAT_WR = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0b;
  localparam logic [7:0] CMD_DUAL_OUT = 8'h3b;
  localparam logic [7:0] CMD_DUAL_IO = 8'hbb;
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6b;
  localparam logic [7:0] CMD_QUAD_IO = 8'heb;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_FOUR_K_WIPE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] CMD_FULL_WIPE = 8'hc7;
  // status word bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_BP_HI = 6;
  localparam int SB_SRP_LO = 7;
  localparam int SB_SRP_HI = 8;
  localparam int SB_QE = 9;
  localparam int SB_PSUS = 10;
  localparam int SB_CMP = 14;
  localparam int SB_ESUS = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_WR_MASK = 16'h47fc;
  localparam logic [15:0] STATUS_OTP_MASK = 16'h3800;
  // lane widths and phase lengths in serial clocks
  localparam logic [2:0] LN_X1 = 3'h1;
  localparam logic [2:0] LN_X2 = 3'h2;
  localparam logic [2:0] LN_X4 = 3'h4;
  localparam logic [4:0] ADDR_CLK_X1 = 5'h18;
  localparam logic [4:0] ADDR_CLK_X2 = 5'h0c;
  localparam logic [4:0] ADDR_CLK_X4 = 5'h06;
  localparam logic [4:0] DUMMY_FAST = 5'h08;
  localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
  localparam logic [4:0] DUMMY_QUAD_IO = 5'h06;
  // synchroniser bit indices: {io3..io0, clock, select}
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_NUM = 6;
  // internal operations handed to the array engine
  localparam logic [2:0] OP_STATUS = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_FOUR_K = 3'h2;
  localparam logic [2:0] OP_BLOCK = 3'h3;
  localparam logic [2:0] OP_FULL = 3'h4;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DOUT = 7'h10,
    ST_DIN = 7'h20,
    ST_TAIL = 7'h40
  } sfi_state_t;
endpackage

// *** design/sfi_fifo.sv ***
/*
  Word FIFO between the array read stream and the serial shifter.
  Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/1ps
module sfi_fifo #(
  parameter int W = sfi_pkg::FIFO_W,
  parameter int D = sfi_pkg::FIFO_D
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import sfi_pkg::*;
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfi_fifo_t;
  sfi_fifo_t r, n;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];

  always_comb
  begin
    n = r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (flush)
    begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        n.mem[r.wp] = in_data;
        n.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
      end
      if (pop)
        n.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end
endmodule // sfi_fifo

// *** design/sfi_front.sv ***
/*
  Serial command front end of a multi-lane serial flash: framing on select,
  mode 0/3 sampling, x1/x2/x4 lanes, pause, status word and write gating.
  Assumes pins are asynchronous and sampled by sys_clk, and an array engine
  outside streams read bytes and runs program/erase/status operations.
*/
// Notes on behaviour
// RL1 - unknown or refused command: ignore bus until select falls again
// RL2 - output lanes float while ignoring or idle
// RL3 - valid command stays active until select rises
// RL4 - modes 0 and 3; sample on clock rise, drive on clock fall
// RL5 - reads end cleanly whenever select rises
// RL6 - writes execute only if select rises on a byte boundary
// RL7 - array access ignored while busy
// RL8 - dual commands use lanes 0 and 1, two bits per clock
// RL9 - quad commands use four lanes, four bits per clock
// RL10 - quad commands work only with quad_enable set
// RL11 - pause does not stop a running internal operation
// RL12 - pause starts on pause_n low with select low, once clock low
// RL13 - pause ends on pause_n high, once clock low
// RL14 - during pause, output floats and input is ignored
// RL15 - select high during pause resets the interface logic
// RL16 - pause is disabled in quad mode
// RL17 - upper status byte layout
// RL18 - busy_flag high during program, erase or status write
// RL19 - write_enable_latch low refuses status write, program, erase
// RL20 - status write sets block_protect_field unless hw locked
// RL21 - full wipe runs only when no area is protected
// RL22 - host reads status before a command
// RL23 - latch_set_cmd precedes any change
// RL24 - quad_enable turns pins 2 and 3 into lanes
// RL25 - lower status byte layout
`timescale 1ns/1ps
module sfi_front (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // array read stream
  output logic rd_active,
  output logic [23:0] rd_addr,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [sfi_pkg::FIFO_W-1:0] rd_data,
  // array operations
  output logic op_start,
  output logic [2:0] op_kind,
  output logic [23:0] op_addr,
  output logic prog_valid,
  output logic [7:0] prog_data,
  input wire logic op_done,
  // status
  output logic [15:0] status_word
);
  import sfi_pkg::*;
  typedef struct packed {
    logic [PIN_NUM-1:0] s1;
    logic [PIN_NUM-1:0] s2;
    logic [PIN_NUM-1:0] s3;
    logic [PIN_NUM-1:0] f;
    sfi_state_t st;
    logic held;
    logic drv;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [4:0] cnt;
    logic [4:0] dummy;
    logic [2:0] lanes;
    logic [2:0] dlanes;
    logic [2:0] bitpos;
    logic [1:0] nbytes;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [3:0] left;
    logic [15:0] sr;
    logic [15:0] wr;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic rd_active;
    logic rd_ready;
    logic op_start;
    logic [2:0] op_kind;
    logic [23:0] op_addr;
    logic prog_valid;
    logic [7:0] prog_data;
  } sfi_front_t;
  sfi_front_t r, n;
  logic cs_rise, cs_fall, sck_rise, sck_fall;
  logic hold_en, pause_n, wp_n, qe, hw_lock, is_array;
  logic [3:0] din;
  logic [7:0] sh_in_nx, ob, b;
  logic [23:0] addr_nx;
  logic [4:0] addr_clks;
  logic [2:0] bitpos_nx;
  logic fifo_valid, fifo_pop, fifo_ready;
  logic [FIFO_W-1:0] fifo_data;

  // the shifter pulls from here; a full FIFO stalls the array through rd_ready
  sfi_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(!r.rd_active),
    .in_valid(rd_valid),
    .in_ready(fifo_ready),
    .in_data(rd_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb
  begin
    n = r;
    n.s1 = {io_in, serial_clock, select_n};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < PIN_NUM; i++)
    begin
      if (r.s2[i] == r.s3[i])
        n.f[i] = r.s3[i];
    end
    n.rd_ready = fifo_ready;
    cs_rise = !r.f[PIN_CS] && n.f[PIN_CS];
    cs_fall = r.f[PIN_CS] && !n.f[PIN_CS];
    // RL4 sampling edge and driving edge
    sck_rise = !r.f[PIN_SCK] && n.f[PIN_SCK];
    sck_fall = r.f[PIN_SCK] && !n.f[PIN_SCK];
    din = n.f[5:2];
    qe = r.sr[SB_QE];
    // RL24 protect and pause pins lose their control role with quad_enable
    wp_n = qe || din[2];
    pause_n = qe || din[3];
    // RL16 no pause in quad mode
    hold_en = !qe && !n.f[PIN_CS];
    hw_lock = r.sr[SB_SRP_HI] || (r.sr[SB_SRP_LO] && !wp_n);
    is_array = (r.cmd != CMD_STAT_LO) && (r.cmd != CMD_STAT_HI);
    n.op_start = 1'b0;
    n.prog_valid = 1'b0;
    fifo_pop = 1'b0;
    b = 8'h00;
    unique case (r.lanes)
      LN_X2: sh_in_nx = {r.sh_in[5:0], din[1:0]};
      LN_X4: sh_in_nx = {r.sh_in[3:0], din};
      default: sh_in_nx = {r.sh_in[6:0], din[0]};
    endcase
    unique case (r.lanes)
      LN_X2: addr_nx = {r.addr[21:0], din[1:0]};
      LN_X4: addr_nx = {r.addr[19:0], din};
      default: addr_nx = {r.addr[22:0], din[0]};
    endcase
    addr_clks = (r.lanes == LN_X4) ? ADDR_CLK_X4 : (r.lanes == LN_X2) ? ADDR_CLK_X2 : ADDR_CLK_X1;
    bitpos_nx = r.bitpos + r.lanes;
    ob = (r.cmd == CMD_STAT_LO) ? r.sr[7:0] : (r.cmd == CMD_STAT_HI) ? r.sr[15:8] :
         (fifo_valid ? fifo_data : 8'h00);
    // RL11 engine completion is independent of pause and framing
    if (op_done)
      n.sr[SB_BUSY] = 1'b0;
    // RL12 pause begins only while the clock is low
    if (!hold_en)
      n.held = 1'b0;
    else if (!pause_n && !n.f[PIN_SCK])
      n.held = 1'b1;
    // RL13 pause ends only while the clock is low
    else if (pause_n && !n.f[PIN_SCK])
      n.held = 1'b0;
    if (n.f[PIN_CS])
    begin
      if (cs_rise && r.bitpos == 3'h0)
      begin
        // RL6 write-type commands are committed here, byte aligned only
        if (r.st == ST_TAIL)
        begin
          unique case (r.cmd)
            CMD_LATCH_SET: n.sr[SB_WEL] = 1'b1;
            CMD_LATCH_CLR: n.sr[SB_WEL] = 1'b0;
            CMD_FULL_WIPE:
            begin
              // RL21 only with nothing protected
              if (r.sr[SB_WEL] && r.sr[4:2] == 3'h0 && !r.sr[SB_CMP])
              begin
                n.op_start = 1'b1;
                n.op_kind = OP_FULL;
              end
            end
            default:
            begin
              // RL19 RL23 erase needs the latch
              if (r.sr[SB_WEL])
              begin
                n.op_start = 1'b1;
                n.op_kind = (r.cmd == CMD_FOUR_K_WIPE) ? OP_FOUR_K : OP_BLOCK;
              end
            end
          endcase
        end
        else if (r.st == ST_DIN && r.nbytes != 2'h0 && r.sr[SB_WEL])
        begin
          if (r.cmd == CMD_PAGE_PROG)
          begin
            n.op_start = 1'b1;
            n.op_kind = OP_PROG;
          end
          // RL20 status write refused under hardware protection
          else if (!hw_lock && r.nbytes != 2'h3)
          begin
            n.op_start = 1'b1;
            n.op_kind = OP_STATUS;
            n.sr[7:0] = (r.sr[7:0] & ~STATUS_WR_MASK[7:0]) | (r.wr[7:0] & STATUS_WR_MASK[7:0]);
            if (r.nbytes == 2'h2)
              n.sr[15:8] = (r.sr[15:8] & ~STATUS_WR_MASK[15:8]) | (r.wr[15:8] & STATUS_WR_MASK[15:8])
                           | (r.sr[15:8] & STATUS_OTP_MASK[15:8]);
          end
        end
        // RL18 busy from commit until the engine reports done
        if (n.op_start)
        begin
          n.sr[SB_BUSY] = 1'b1;
          n.sr[SB_WEL] = 1'b0;
          n.op_addr = r.addr;
        end
      end
      // RL15 deselect resets the interface, pause included
      // RL5 read streams stop wherever select rises
      n.st = ST_IDLE;
      n.held = 1'b0;
      n.drv = 1'b0;
      n.rd_active = 1'b0;
    end
    else if (cs_fall)
    begin
      n.st = ST_CMD;
      n.cnt = 5'h00;
      n.bitpos = 3'h0;
      n.nbytes = 2'h0;
      n.lanes = LN_X1;
      n.left = 4'h0;
      n.drv = 1'b0;
    end
    // RL14 input ignored while paused
    else if (!n.held)
    begin
      unique case (r.st)
        // RL1 wait for the next select falling edge
        ST_IDLE: n.st = ST_IDLE;
        ST_CMD:
        begin
          if (sck_rise)
          begin
            n.sh_in = sh_in_nx;
            n.bitpos = bitpos_nx;
            if (r.bitpos == 3'h7)
            begin
              n.cmd = sh_in_nx;
              n.cnt = 5'h00;
              n.dummy = 5'h00;
              n.dlanes = LN_X1;
              n.st = ST_ADDR;
              unique case (sh_in_nx)
                // RL3 recognised commands stay active
                CMD_STAT_LO, CMD_STAT_HI: n.st = ST_DOUT;
                CMD_READ: n.st = ST_ADDR;
                CMD_FAST: n.dummy = DUMMY_FAST;
                // RL8 dual lanes
                CMD_DUAL_OUT:
                begin
                  n.dummy = DUMMY_FAST;
                  n.dlanes = LN_X2;
                end
                CMD_DUAL_IO:
                begin
                  n.dummy = DUMMY_DUAL_IO;
                  n.dlanes = LN_X2;
                  n.lanes = LN_X2;
                end
                // RL9 quad lanes
                CMD_QUAD_OUT:
                begin
                  n.dummy = DUMMY_FAST;
                  n.dlanes = LN_X4;
                end
                CMD_QUAD_IO:
                begin
                  n.dummy = DUMMY_QUAD_IO;
                  n.dlanes = LN_X4;
                  n.lanes = LN_X4;
                end
                CMD_LATCH_SET, CMD_LATCH_CLR, CMD_FULL_WIPE: n.st = ST_TAIL;
                CMD_STAT_WR: n.st = ST_DIN;
                CMD_PAGE_PROG, CMD_FOUR_K_WIPE, CMD_BLOCK_WIPE: n.st = ST_ADDR;
                default: n.st = ST_IDLE;
              endcase
              // RL10 quad needs quad_enable
              if ((sh_in_nx == CMD_QUAD_OUT || sh_in_nx == CMD_QUAD_IO) && !qe)
                n.st = ST_IDLE;
              // RL7 only status reads while an operation runs
              if (r.sr[SB_BUSY] && sh_in_nx != CMD_STAT_LO && sh_in_nx != CMD_STAT_HI)
                n.st = ST_IDLE;
            end
          end
        end
        ST_ADDR:
        begin
          if (sck_rise)
          begin
            n.addr = addr_nx;
            n.cnt = r.cnt + 5'h01;
            n.bitpos = bitpos_nx;
            if (n.cnt == addr_clks)
            begin
              n.cnt = 5'h00;
              n.lanes = LN_X1;
              if (r.cmd == CMD_PAGE_PROG)
                n.st = ST_DIN;
              else if (r.cmd == CMD_FOUR_K_WIPE || r.cmd == CMD_BLOCK_WIPE)
                n.st = ST_TAIL;
              else
              begin
                // start streaming early so the dummy clocks fill the FIFO
                n.rd_active = 1'b1;
                n.st = (r.dummy == 5'h00) ? ST_DOUT : ST_DUMMY;
                n.lanes = r.dlanes;
              end
            end
          end
        end
        ST_DUMMY:
        begin
          if (sck_rise)
          begin
            n.cnt = r.cnt + 5'h01;
            if (n.cnt == r.dummy)
              n.st = ST_DOUT;
          end
        end
        ST_DOUT:
        begin
          // RL4 new output group after each falling clock
          if (sck_fall)
          begin
            n.drv = 1'b1;
            b = (r.left == 4'h0) ? ob : r.sh_out;
            fifo_pop = (r.left == 4'h0) && is_array && fifo_valid;
            n.left = ((r.left == 4'h0) ? 4'h8 : r.left) - {1'b0, r.lanes};
            unique case (r.lanes)
              LN_X2:
              begin
                n.io_out = {2'b00, b[7:6]};
                n.sh_out = {b[5:0], 2'b00};
              end
              LN_X4:
              begin
                n.io_out = b[7:4];
                n.sh_out = {b[3:0], 4'h0};
              end
              default:
              begin
                n.io_out = {2'b00, b[7], 1'b0};
                n.sh_out = {b[6:0], 1'b0};
              end
            endcase
          end
        end
        ST_DIN:
        begin
          if (sck_rise)
          begin
            n.sh_in = sh_in_nx;
            n.bitpos = bitpos_nx;
            if (r.bitpos == 3'h7)
            begin
              if (r.nbytes != 2'h3)
                n.nbytes = r.nbytes + 2'h1;
              if (r.nbytes == 2'h0)
                n.wr[7:0] = sh_in_nx;
              else if (r.nbytes == 2'h1)
                n.wr[15:8] = sh_in_nx;
              if (r.cmd == CMD_PAGE_PROG)
              begin
                n.prog_valid = 1'b1;
                n.prog_data = sh_in_nx;
              end
            end
          end
        end
        ST_TAIL:
        begin
          // RL6 extra bits after a fixed-length command spoil it
          if (sck_rise)
            n.st = ST_IDLE;
        end
        default: n.st = ST_IDLE;
      endcase
    end
    // RL2 lanes float unless a data phase is driving
    // RL14 output floats from pause_n low
    n.io_oe = 4'h0;
    if (n.st == ST_DOUT && n.drv && !(hold_en && !pause_n))
      n.io_oe = (r.lanes == LN_X4) ? 4'hf : (r.lanes == LN_X2) ? 4'h3 : 4'h2;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.s1 <= 6'h3f;
      r.s2 <= 6'h3f;
      r.s3 <= 6'h3f;
      r.f <= 6'h3f;
      // RL17 RL25 status word layout
      r.sr <= STATUS_RESET;
      r.lanes <= LN_X1;
      r.dlanes <= LN_X1;
    end
    else
      r <= n;
  end

  assign io_out = r.io_out;
  assign io_oe = r.io_oe;
  assign rd_active = r.rd_active;
  assign rd_addr = r.addr;
  assign rd_ready = r.rd_ready;
  assign op_start = r.op_start;
  assign op_kind = r.op_kind;
  assign op_addr = r.op_addr;
  assign prog_valid = r.prog_valid;
  assign prog_data = r.prog_data;
  assign status_word = r.sr;
endmodule // sfi_front

// *** sim/sfi_front_props.sv ***
/*
  Port checks for sfi_front, bound at the foot.
  Assumes one sys_clk domain, rst_n async active low.
*/
`timescale 1ns/1ps
module sfi_front_props
  import sfi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_oe,
  // array side
  input wire logic rd_active,
  input wire logic op_start,
  input wire logic [2:0] op_kind,
  input wire logic op_done,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // eight cycles leave room for the pin synchronisers
  sequence s_desel;
    select_n [*8];
  endsequence
  sequence s_paused;
    (!select_n && !serial_clock && !io_in[3] && !status_word[SB_QE]) [*8];
  endsequence
  property p_idle_float;
    s_desel |-> io_oe == 4'h0;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("lanes driven while deselected");
  property p_idle_noread;
    s_desel |-> !rd_active;
  endproperty
  a_idle_noread: assert property (p_idle_noread) else $error("read stream open after deselect");
  property p_pause_float;
    s_paused |-> io_oe == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("lanes driven during pause");
  property p_start_flags;
    op_start |-> status_word[SB_BUSY] && !status_word[SB_WEL];
  endproperty
  a_start_flags: assert property (p_start_flags) else $error("busy or latch wrong at commit");
  property p_latch_first;
    op_start |-> $past(status_word[SB_WEL]);
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("commit without latch");
  property p_busy_holds;
    status_word[SB_BUSY] && !op_done |=> status_word[SB_BUSY];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");
  property p_busy_ends;
    status_word[SB_BUSY] && op_done |=> !status_word[SB_BUSY];
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy kept after done");
  property p_busy_cause;
    $rose(status_word[SB_BUSY]) |-> op_start;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without commit");
  property p_full_free;
    op_start && op_kind == OP_FULL |-> $past(status_word[SB_BP_LO+2:SB_BP_LO]) == 3'h0 && !$past(status_word[SB_CMP]);
  endproperty
  a_full_free: assert property (p_full_free) else $error("full wipe with protected area");
  property p_quad_gate;
    io_oe[3:2] != 2'h0 |-> status_word[SB_QE];
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("upper lanes driven without quad enable");
  property p_lane_sets;
    io_oe inside {4'h0, 4'h2, 4'h3, 4'hf};
  endproperty
  a_lane_sets: assert property (p_lane_sets) else $error("odd lane enable set");
endmodule // sfi_front_props
bind sfi_front sfi_front_props sfi_front_props_i (.*);

// *** sim/sfi_host.sv ***
/*
  Behavioural host controller for the serial flash pins.
  Assumes callers enter its tasks just after a falling sys_clk edge.
*/
`timescale 1ns/1ps
module sfi_host (
  // time base
  input wire logic sys_clk,
  // serial pins
  output logic select_n,
  output logic serial_clock,
  output logic [3:0] hd,
  input wire logic [3:0] pin
);
  logic mode3;
  initial
  begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    hd = 4'hc;
    mode3 = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic start(input logic m3);
    mode3 = m3;
    serial_clock <= m3;
    tick(2);
    select_n <= 1'b0;
    tick(4);
  endtask
  // drive on fall, read late in high phase
  task automatic shift(input logic [7:0] b, input int ln, input int nc, output logic [7:0] r);
    logic [7:0] sh;
    sh = b;
    r = 8'h00;
    for (int k = 0; k < nc; k++)
    begin
      serial_clock <= 1'b0;
      case (ln)
        1: hd[0] <= sh[7];
        2: hd[1:0] <= sh[7:6];
        default: hd <= sh[7:4];
      endcase
      tick(4);
      serial_clock <= 1'b1;
      tick(4);
      r = (r << ln) | 8'(ln == 1 ? pin[1] : (ln == 2 ? pin[1:0] : pin));
      sh = sh << ln;
    end
  endtask
  // select rises wherever the last shift ended, even mid-byte
  task automatic stop();
    if (!mode3)
      serial_clock <= 1'b0;
    tick(2);
    select_n <= 1'b1;
    hd <= 4'hc;
    tick(8);
  endtask
  task automatic pause(input logic v);
    hd[3] <= v;
    tick(2);
    serial_clock <= 1'b0;
    tick(10);
  endtask
endmodule // sfi_host

// *** sim/sfi_front_tb.sv ***
/*
  Self-checking bench for sfi_front with host model and engine stub.
  Assumes the stub answers on the rising edge by NBA.
*/
`timescale 1ns/1ps
module sfi_front_tb;
  import sfi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic select_n, serial_clock, rd_active, rd_ready, op_start, prog_valid;
  logic rd_valid = 1'b0;
  logic op_done = 1'b0;
  logic [3:0] io_in, io_out, io_oe, hd;
  logic [23:0] rd_addr, op_addr;
  logic [7:0] rd_data, prog_data, v;
  logic [7:0] cnt = 8'h00;
  logic [2:0] op_kind;
  logic [2:0] last_kind = 3'h0;
  logic [15:0] status_word;
  int bad_count = 0;
  int check_count = 0;
  int starts = 0;
  int busy_cnt = 0;
  always #10 sys_clk = ~sys_clk;
  assign io_in = (io_oe & io_out) | (~io_oe & hd);
  assign rd_data = 8'h40 + cnt;
  sfi_front sfi_front_i (.*);
  sfi_host sfi_host_i (.sys_clk(sys_clk), .select_n(select_n), .serial_clock(serial_clock), .hd(hd), .pin(io_in));
  // engine stub; late ready may cost one refused push
  always @(posedge sys_clk)
  begin
    op_done <= (busy_cnt == 1);
    if (op_start)
    begin
      busy_cnt <= 1000;
      starts <= starts + 1;
      last_kind <= op_kind;
    end
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
    if (!rd_active)
      cnt <= 8'h00;
    else if (rd_valid && rd_ready)
      cnt <= cnt + 8'h01;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic sh(input logic [7:0] b, input int ln, input int nc);
    sfi_host_i.shift(b, ln, nc, v);
  endtask
  task automatic frame(input logic [7:0] c, input logic m3);
    sfi_host_i.start(m3);
    sh(c, 1, 8);
  endtask
  task automatic one(input logic [7:0] c);
    frame(c, 1'b0);
    sfi_host_i.stop();
  endtask
  task automatic rd_stat(input logic [7:0] c);
    frame(c, 1'b1);
    sh(8'h00, 1, 8);
    sfi_host_i.stop();
  endtask
  task automatic wr_stat(input logic [7:0] lo, input logic [7:0] hi, input int nc);
    rd_stat(CMD_STAT_LO);
    one(CMD_LATCH_SET);
    frame(CMD_STAT_WR, 1'b0);
    sh(lo, 1, 8);
    sh(hi, 1, nc);
    sfi_host_i.stop();
  endtask
  task automatic wait_idle();
    for (int n = 0; status_word[SB_BUSY] !== 1'b0; n++)
    begin
      if (n == 2000)
      begin
        check("busy wait", 24'(status_word[SB_BUSY]), 24'h0);
        tally_and_finish();
      end
      @(negedge sys_clk);
    end
  endtask
  task automatic t_status();
    check("status reset", 24'(status_word), 24'(STATUS_RESET));
    wr_stat(8'h1c, 8'h40, 8);
    frame(CMD_READ, 1'b0);
    repeat (5) sh(8'h00, 1, 8);
    check("read while busy", 24'(rd_active), 24'h0);
    sfi_host_i.stop();
    rd_stat(CMD_STAT_LO);
    check("busy low byte", 24'(v), 24'h1d);
    wait_idle();
    rd_stat(CMD_STAT_LO);
    check("low byte", 24'(v), 24'h1c);
    rd_stat(CMD_STAT_HI);
    check("high byte", 24'(v), 24'h40);
    check("status kind", 24'(last_kind), 24'(OP_STATUS));
    $display("test status done");
  endtask
  task automatic t_refuse();
    int s;
    s = starts;
    frame(8'hff, 1'b0);
    repeat (2) sh(8'h00, 1, 8);
    check("unknown lanes", 24'(io_oe), 24'h0);
    sfi_host_i.stop();
    frame(CMD_STAT_WR, 1'b0);
    sh(8'h00, 1, 8);
    sfi_host_i.stop();
    check("no latch", 24'(starts), 24'(s));
    wr_stat(8'h00, 8'h00, 7);
    check("odd bits", 24'(starts), 24'(s));
    one(CMD_LATCH_SET);
    one(CMD_FULL_WIPE);
    check("wipe protected", 24'(starts), 24'(s));
    one(CMD_LATCH_CLR);
    rd_stat(CMD_STAT_LO);
    check("latch clear", 24'(v), 24'h1c);
    wr_stat(8'h00, 8'h00, 8);
    wait_idle();
    one(CMD_LATCH_SET);
    one(CMD_FULL_WIPE);
    wait_idle();
    check("wipe free", 24'(starts), 24'(s + 2));
    check("wipe kind", 24'(last_kind), 24'(OP_FULL));
    $display("test refuse done");
  endtask
  task automatic t_pause();
    frame(CMD_STAT_LO, 1'b1);
    sh(8'h00, 1, 4);
    sfi_host_i.pause(1'b0);
    check("paused lanes", 24'(io_oe), 24'h0);
    sfi_host_i.pause(1'b1);
    check("resumed lanes", 24'(io_oe), 24'h2);
    sfi_host_i.pause(1'b0);
    sfi_host_i.stop();
    rd_stat(CMD_STAT_LO);
    check("after pause", 24'(v), 24'h00);
    $display("test pause done");
  endtask
  task automatic t_reads();
    logic [7:0] cm [6] = '{CMD_READ, CMD_FAST, CMD_DUAL_OUT, CMD_DUAL_IO, CMD_QUAD_OUT, CMD_QUAD_IO};
    int al [6] = '{1, 1, 1, 2, 1, 4};
    int dm [6] = '{0, 8, 8, 4, 8, 6};
    int dl [6] = '{1, 1, 2, 2, 4, 4};
    frame(CMD_QUAD_OUT, 1'b0);
    repeat (5) sh(8'h00, 1, 8);
    check("quad refused", 24'(io_oe), 24'h0);
    sfi_host_i.stop();
    wr_stat(8'h00, 8'h02, 8);
    wait_idle();
    for (int i = 0; i < 6; i++)
    begin
      rd_valid = 1'b1;
      frame(cm[i], i[0]);
      repeat (3) sh(8'h5a, al[i], 8 / al[i]);
      sh(8'h00, al[i], dm[i]);
      sfi_host_i.tick(40);
      check("read addr", rd_addr, 24'h5a5a5a);
      check("fifo full", 24'(rd_ready), 24'h0);
      rd_valid = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
        sh(8'h00, dl[i], 8 / dl[i]);
        check("read byte", 24'(v), 24'(8'h40 + k));
      end
      check("read lanes", 24'(io_oe), dl[i] == 1 ? 24'h2 : 24'((1 << dl[i]) - 1));
      sh(8'h00, dl[i], 1);
      sfi_host_i.stop();
      check("read closed", 24'(rd_active), 24'h0);
    end
    frame(CMD_STAT_LO, 1'b0);
    sh(8'h00, 1, 4);
    sfi_host_i.pause(1'b0);
    check("quad no pause", 24'(io_oe), 24'h2);
    sfi_host_i.stop();
    $display("test reads done");
  endtask
  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_status();
    t_refuse();
    t_pause();
    t_reads();
    tally_and_finish();
  end
endmodule // sfi_front_tb
